// ===== core/pas_pkg.sv
//
// Function
// [R1] Advance edge rotates output order when advance is on and style is not direct.
// [R2] In direct style advance edges leave the output mapping unchanged.
// [R3] Make-first: next output switches on before relieved output switches off.
// [R4] Break-first: relieved output switches off, then next output switches on.
// [R5] Lost in-use output is replaced break-first regardless of hand-over option.
// [R6] Hand-over option applies to fixed, rotary and first-on-first-off styles.
// [R7] One on-delay and one off-delay shared by all outputs and hand-over.
// [R8] On-delay wait aborted, output unchanged, when output no longer wanted.
// [R9] Off-delay wait aborted, output unchanged, when output wanted again.
// [R10] Outputs switch one at a time, each after its delay, in order.
// [R11] On-delay is whole seconds 0..99999, default zero, run-time changeable.
// [R12] Off-delay is whole seconds 0..99999, default zero, run-time changeable.
// [R13] Hand-over option: one make-first, zero break-first, default make-first.
// [R14] Advance enable is fixed at configuration, caught only during reset.
// [R15] Style is direct, rotary, first-on-first-off or fixed, run-time changeable.
// [R16] Each demand input has an enable, default on; disabled reads as off.
// [R17] Each output has an enable, default on; disabled output stays off.
// [R18] Device-ready option off means every device counts as ready.
// [R19] Style change waits until all sixteen demand inputs are off.
// [R20] Disable stops evaluation, clears timers, keeps style, outputs and run low.
// [R21] Ready bit n qualifies output n; a cleared bit forces that output off.
// [R22] Rotary: demand counts inputs, last-on-first-off, order advances at zero.
// [R23] Delays counted from a one-second tick derived from the system clock.
// [R24] Demand is the count of enabled active inputs, mapped through the order.
//
package pas_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int IDX_W = 4;
    localparam int CNT_W = 5;
    localparam int DELAY_W = 17;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 17'h1869f;
    localparam logic [DELAY_W-1:0] ON_DELAY_RST = 17'h00000;
    localparam logic [DELAY_W-1:0] OFF_DELAY_RST = 17'h00000;
    localparam int CLK_HZ = 125000000;
    localparam int TICK_SEC = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;
    localparam logic MAKE_FIRST_RST = 1'b1;
    localparam logic [NUM_CH-1:0] ENABLES_RST = 16'hffff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PAS_DIRECT,
        PAS_ROTARY,
        PAS_FIRST_ON_FIRST_OFF,
        PAS_FIXED
    } pas_style_e;

    typedef struct packed {
        logic [DELAY_W-1:0] on_delay_sec;
        logic [DELAY_W-1:0] off_delay_sec;
        logic make_first_handover;
        pas_style_e style_req;
        logic [NUM_CH-1:0] input_enable;
        logic [NUM_CH-1:0] output_enable;
        logic device_ready_use;
    } pas_cfg_s;

    typedef struct packed {
        logic run_state_out;
        logic outputs_disabled;
        logic inputs_disabled;
        pas_style_e style_active;
        logic [CNT_W-1:0] demand;
    } pas_status_s;

endpackage

// ===== core/pas_core.sv
module pas_core #(
    parameter int TICK_CYCLES = pas_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [pas_pkg::NUM_CH-1:0] demand_in,
    input wire logic block_disable,
    input wire logic advance_request,
    input wire logic advance_enable,
    input wire logic [pas_pkg::NUM_CH-1:0] device_ready_word,
    input wire pas_pkg::pas_cfg_s cfg,
    output logic [pas_pkg::NUM_CH-1:0] device_out,
    output pas_pkg::pas_status_s status
);
    import pas_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("pas_core: TICK_CYCLES must be at least one");
    end
    if (NUM_CH > (1 << IDX_W)) begin : g_bad_idx
        $error("pas_core: IDX_W is too narrow to index every channel");
    end
    if (NUM_CH >= (1 << CNT_W)) begin : g_bad_cnt
        $error("pas_core: CNT_W is too narrow for a full demand count");
    end

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef enum logic [1:0] {
        PAS_IDLE,
        PAS_WAIT_ON,
        PAS_WAIT_OFF
    } pas_step_e;

    logic [TW-1:0] tick_cnt_reg;
    logic sec_tick;
    logic adv_prev_reg;
    logic adv_en_reg;
    pas_style_e style_reg;
    logic [IDX_W-1:0] order_reg [NUM_CH];
    logic [CNT_W-1:0] demand_prev_reg;
    logic [NUM_CH-1:0] out_reg;
    pas_step_e step_reg;
    logic [IDX_W-1:0] chan_reg;
    logic [DELAY_W-1:0] sec_cnt_reg;

    logic [NUM_CH-1:0] in_eff;
    logic [NUM_CH-1:0] ready;
    logic [NUM_CH-1:0] avail;
    logic [CNT_W-1:0] demand;
    logic [NUM_CH-1:0] target;
    logic want_on;
    logic want_off;
    logic [IDX_W-1:0] on_pick;
    logic [IDX_W-1:0] off_pick;
    logic adv_edge;
    logic rotate;
    logic off_first;
    logic [DELAY_W-1:0] delay_sel;
    logic delay_done;
    logic [NUM_CH-1:0] chan_bit;
    logic last_off;

    // ------------------------------------------------------------
    // One-second timebase
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + TW'(1);
        end
    end

    assign sec_tick = (tick_cnt_reg == TICK_LAST); // R23

    // ------------------------------------------------------------
    // Qualified inputs and outputs
    // ------------------------------------------------------------
    assign in_eff = demand_in & cfg.input_enable; // R16
    assign ready = cfg.device_ready_use ? device_ready_word : '1; // R18
    assign avail = cfg.output_enable & ready; // R17 R21

    always_comb begin
        demand = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            demand = demand + CNT_W'(in_eff[i]); // R24
        end
    end

    // Demand positions walk the order, skipping unavailable outputs
    always_comb begin
        logic [CNT_W-1:0] used;
        used = '0;
        target = '0;
        for (int p = 0; p < NUM_CH; p++) begin
            if (style_reg == PAS_DIRECT) begin
                if (in_eff[p]) begin
                    target[order_reg[p]] = avail[order_reg[p]];
                end
            end else if (avail[order_reg[p]] && used < demand) begin
                target[order_reg[p]] = 1'b1; // R22 R24
                used = used + CNT_W'(1);
            end
        end
    end

    // First position to start, last position to stop
    always_comb begin
        want_on = 1'b0;
        want_off = 1'b0;
        on_pick = '0;
        off_pick = '0;
        for (int p = NUM_CH - 1; p >= 0; p--) begin
            if (target[order_reg[p]] && !out_reg[order_reg[p]]) begin
                want_on = 1'b1;
                on_pick = order_reg[p]; // R10
            end
        end
        for (int p = 0; p < NUM_CH; p++) begin
            if (!target[order_reg[p]] && out_reg[order_reg[p]]) begin
                want_off = 1'b1;
                off_pick = order_reg[p]; // R22
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration capture and style
    // ------------------------------------------------------------
    // Advance enable is a build-time choice, so it is only sampled in reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adv_en_reg <= advance_enable; // R14
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            style_reg <= cfg.style_req;
        end else if (demand_in == '0) begin
            style_reg <= cfg.style_req; // R15 R19
        end
    end

    // ------------------------------------------------------------
    // Sequence order rotation
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adv_prev_reg <= 1'b0;
            demand_prev_reg <= '0;
        end else begin
            adv_prev_reg <= advance_request;
            demand_prev_reg <= demand;
        end
    end

    assign adv_edge = advance_request && !adv_prev_reg;

    assign chan_bit = NUM_CH'(1) << chan_reg;
    // Rotating mid shut-down would reshuffle the stop order, so wait for
    // the last running output to be switched off
    assign last_off = step_reg == PAS_WAIT_OFF && !target[chan_reg] &&
                      delay_done && (out_reg & avail & ~chan_bit) == '0;

    always_comb begin
        rotate = 1'b0;
        if (!block_disable && style_reg != PAS_DIRECT) begin // R2
            if (adv_edge && adv_en_reg) begin
                rotate = 1'b1; // R1
            end
            if (style_reg == PAS_ROTARY && demand == '0 &&
                (last_off || (demand_prev_reg != '0 && out_reg == '0))) begin
                rotate = 1'b1; // R22
            end
            if (style_reg == PAS_FIRST_ON_FIRST_OFF &&
                demand < demand_prev_reg) begin
                rotate = 1'b1;
            end
        end
    end

    for (genvar p = 0; p < NUM_CH; p++) begin : g_order
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                order_reg[p] <= IDX_W'(p);
            end else if (rotate) begin
                order_reg[p] <= order_reg[(p + 1) % NUM_CH];
            end
        end
    end

    // ------------------------------------------------------------
    // Hand-over sequencing
    // ------------------------------------------------------------
    // Break-first always while any running output has been lost
    assign off_first = !cfg.make_first_handover ||
                       ((out_reg & ~avail) != '0); // R4 R5 R6 R13

    assign delay_sel = (step_reg == PAS_WAIT_ON) ? cfg.on_delay_sec
                                                 : cfg.off_delay_sec; // R7
    // Values above the range saturate to the top of the range
    assign delay_done = sec_cnt_reg >= ((delay_sel > DELAY_MAX) ? DELAY_MAX
                                                                : delay_sel);

    always_ff @(posedge clk) begin
        if (sys_rst || block_disable) begin
            step_reg <= PAS_IDLE; // R20
            chan_reg <= '0;
        end else begin
            case (step_reg)
                PAS_IDLE: begin
                    if (want_off && (off_first || !want_on)) begin
                        step_reg <= PAS_WAIT_OFF; // R4
                        chan_reg <= off_pick;
                    end else if (want_on) begin
                        step_reg <= PAS_WAIT_ON; // R3
                        chan_reg <= on_pick;
                    end
                end
                PAS_WAIT_ON: begin
                    if (!target[chan_reg] || delay_done) begin
                        step_reg <= PAS_IDLE; // R8
                    end
                end
                PAS_WAIT_OFF: begin
                    if (target[chan_reg] || delay_done) begin
                        step_reg <= PAS_IDLE; // R9
                    end
                end
                default: begin
                    step_reg <= PAS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || block_disable || step_reg == PAS_IDLE) begin
            sec_cnt_reg <= '0; // R8 R9 R20
        end else if (sec_tick && sec_cnt_reg != DELAY_MAX) begin
            sec_cnt_reg <= sec_cnt_reg + DELAY_W'(1); // R11 R12
        end
    end

    // ------------------------------------------------------------
    // Output commands
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || block_disable) begin
            out_reg <= '0; // R20
        end else begin
            // Lost devices drop at once, no off-delay
            out_reg <= out_reg & avail; // R5 R21
            if (step_reg == PAS_WAIT_ON && target[chan_reg] && delay_done) begin
                out_reg[chan_reg] <= avail[chan_reg]; // R10
            end
            if (step_reg == PAS_WAIT_OFF && !target[chan_reg] && delay_done)
            begin
                out_reg[chan_reg] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= '0;
        end else begin
            status.run_state_out <= !block_disable; // R20
            status.outputs_disabled <= cfg.output_enable != '1;
            status.inputs_disabled <= cfg.input_enable != '1;
            status.style_active <= style_reg;
            status.demand <= demand;
        end
    end

    assign device_out = out_reg;

endmodule

// ===== tb/pas_checker.sv
module pas_checker
    import pas_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [pas_pkg::NUM_CH-1:0] demand_in,
    input wire logic block_disable,
    input wire logic advance_request,
    input wire logic advance_enable,
    input wire logic [pas_pkg::NUM_CH-1:0] device_ready_word,
    input wire pas_pkg::pas_cfg_s cfg,
    input wire logic [pas_pkg::NUM_CH-1:0] device_out,
    input wire pas_pkg::pas_status_s status
);
    import pas_pkg::*;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [NUM_CH-1:0] avail;
    assign avail = cfg.output_enable
        & (cfg.device_ready_use ? device_ready_word : 16'hffff);
    default clocking cb @(posedge clk); endclocking
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    reset_clear_a: assert property (sys_rst |=> device_out == 16'h0000
        && !status.run_state_out) else $error("outputs not clear in reset");
    disable_off_a: assert property (disable iff (sys_rst)
        block_disable ##1 block_disable |-> device_out == 16'h0000
        && !status.run_state_out) else $error("outputs on while disabled");
    run_state_a: assert property (disable iff (sys_rst)
        !block_disable |=> status.run_state_out) else $error("run low");
    one_rise_a: assert property (disable iff (sys_rst)
        $countones(device_out & ~$past(device_out)) <= 1)
        else $error("two outputs rose together");
    unavail_drop_a: assert property (disable iff (sys_rst)
        1'b1 |=> (device_out & ~$past(avail)) == 16'h0000)
        else $error("unavailable output left on");
    demand_count_a: assert property (disable iff (sys_rst)
        !block_disable && status.style_active != PAS_DIRECT
        |=> status.demand == $countones($past(demand_in & cfg.input_enable)))
        else $error("demand count wrong");
    enable_flags_a: assert property (disable iff (sys_rst)
        1'b1 |=> status.inputs_disabled == ($past(cfg.input_enable) != 16'hffff)
        && status.outputs_disabled == ($past(cfg.output_enable) != 16'hffff))
        else $error("enable flags wrong");
    style_hold_a: assert property (disable iff (sys_rst)
        $past(demand_in) != 16'h0000 && demand_in != 16'h0000
        |=> $stable(status.style_active)) else $error("style changed early");
endmodule

bind pas_core pas_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .demand_in(demand_in), .block_disable(block_disable),
    .advance_request(advance_request), .advance_enable(advance_enable),
    .device_ready_word(device_ready_word), .cfg(cfg),
    .device_out(device_out), .status(status));

// ===== tb/pas_far_model.sv
module pas_far_model
    import pas_pkg::*;
(
    input wire logic clk,
    input wire logic [pas_pkg::NUM_CH-1:0] want_demand,
    input wire logic [pas_pkg::NUM_CH-1:0] want_ready,
    output logic [pas_pkg::NUM_CH-1:0] demand_in,
    output logic [pas_pkg::NUM_CH-1:0] device_ready_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import pas_pkg::*;
    // Levels follow the bench at once, so they move on the falling edge
    always_comb begin
        demand_in = want_demand;
        device_ready_word = want_ready;
    end
endmodule

// ===== tb/testbench.sv
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pas_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic block_disable = 1'b0;
    logic advance_request = 1'b0;
    logic advance_enable = 1'b1;
    logic [NUM_CH-1:0] want_demand = 16'h0000;
    logic [NUM_CH-1:0] want_ready = 16'hffff;
    logic [NUM_CH-1:0] demand_in, device_ready_word, device_out;
    pas_cfg_s cfg = '{ON_DELAY_RST, OFF_DELAY_RST, MAKE_FIRST_RST,
        PAS_ROTARY, ENABLES_RST, ENABLES_RST, 1'b0};
    pas_status_s status;
    int miscompares = 0;
    int num_checks = 0;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    initial forever #4 clk = ~clk;
    pas_far_model far (.clk(clk), .want_demand(want_demand),
        .want_ready(want_ready), .demand_in(demand_in),
        .device_ready_word(device_ready_word));
    // Short tick keeps second-based delays to a few cycles
    pas_core #(.TICK_CYCLES(4)) DUT (.clk(clk), .sys_rst(sys_rst),
        .demand_in(demand_in), .block_disable(block_disable),
        .advance_request(advance_request), .advance_enable(advance_enable),
        .device_ready_word(device_ready_word), .cfg(cfg),
        .device_out(device_out), .status(status));
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_out(input string n, input logic [NUM_CH-1:0] e);
        for (int i = 0; i < 60 && device_out !== e; i++) step(1);
        `CHK(n, e, device_out)
    endtask
    task automatic do_reset(input pas_style_e s);
        cfg.style_req = s;
        want_demand = 16'h0000;
        sys_rst = 1'b1;
        step(3);
        `CHK("out_rst", 16'h0000, device_out)
        sys_rst = 1'b0;
    endtask
    task automatic pulse_adv;
        advance_request = 1'b1;
        step(1);
        advance_request = 1'b0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_cascade;
        do_reset(PAS_ROTARY);
        want_demand = 16'h0007;
        wait_out("c1", 16'h0001);
        wait_out("c2", 16'h0003);
        wait_out("c3", 16'h0007);
        want_demand = 16'h0000;
        wait_out("d1", 16'h0003);
        wait_out("d2", 16'h0001);
        wait_out("d3", 16'h0000);
        want_demand = 16'h0001;
        wait_out("rot", 16'h0002);
    endtask
    task automatic t_handover;
        cfg.on_delay_sec = 17'h1;
        cfg.off_delay_sec = 17'h1;
        pulse_adv;
        wait_out("mk1", 16'h0006);
        wait_out("mk2", 16'h0004);
        cfg.make_first_handover = 1'b0;
        pulse_adv;
        wait_out("bk1", 16'h0000);
        wait_out("bk2", 16'h0008);
        cfg.device_ready_use = 1'b1;
        want_ready = 16'hfff7;
        wait_out("lost0", 16'h0000);
        wait_out("lost1", 16'h0010);
        cfg.device_ready_use = 1'b0;
        wait_out("rdy", 16'h0008);
        cfg.on_delay_sec = 17'h0;
        cfg.off_delay_sec = 17'h0;
    endtask
    task automatic t_enables;
        cfg.output_enable = 16'hfff7;
        wait_out("oen", 16'h0010);
        `CHK("odis", 1'b1, status.outputs_disabled)
        cfg.output_enable = 16'hffff;
        cfg.input_enable = 16'hfffe;
        wait_out("ien", 16'h0000);
        `CHK("idis", 1'b1, status.inputs_disabled)
        `CHK("idem", 5'h00, status.demand)
        cfg.input_enable = 16'hffff;
        wait_out("ien1", 16'h0010);
        block_disable = 1'b1;
        wait_out("dis", 16'h0000);
        `CHK("run0", 1'b0, status.run_state_out)
        `CHK("keep", PAS_ROTARY, status.style_active)
        block_disable = 1'b0;
        step(2);
        `CHK("run1", 1'b1, status.run_state_out)
    endtask
    task automatic t_direct;
        do_reset(PAS_DIRECT);
        want_demand = 16'h0004;
        wait_out("dir", 16'h0004);
        pulse_adv;
        step(20);
        `CHK("dadv", 16'h0004, device_out)
        cfg.style_req = PAS_FIXED;
        step(5);
        `CHK("spend", PAS_DIRECT, status.style_active)
        want_demand = 16'h0000;
        step(5);
        `CHK("snew", PAS_FIXED, status.style_active)
        want_demand = 16'h0001;
        wait_out("fix", 16'h0001);
        advance_enable = 1'b0;
        pulse_adv;
        wait_out("fbrk", 16'h0000);
        wait_out("fadv", 16'h0002);
    endtask
    task automatic t_first_on_first_off_style;
        do_reset(PAS_FIRST_ON_FIRST_OFF);
        want_demand = 16'h0003;
        wait_out("fo2", 16'h0003);
        want_demand = 16'h0001;
        wait_out("fo1", 16'h0002);
    endtask
    task automatic t_delay;
        do_reset(PAS_ROTARY);
        cfg.on_delay_sec = 17'h2;
        want_demand = 16'h0001;
        step(3);
        `CHK("ondly", 16'h0000, device_out)
        want_demand = 16'h0000;
        step(20);
        `CHK("onabt", 16'h0000, device_out)
        want_demand = 16'h0001;
        wait_out("onend", 16'h0002);
        cfg.off_delay_sec = 17'h2;
        want_demand = 16'h0000;
        step(3);
        want_demand = 16'h0001;
        step(20);
        `CHK("offabt", 16'h0002, device_out)
        pulse_adv;
        step(20);
        `CHK("noadv", 16'h0002, device_out)
    endtask
    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        t_cascade;
        t_handover;
        t_enables;
        t_direct;
        t_first_on_first_off_style;
        t_delay;
        conclude;
    end
    initial begin
        #100us;
        miscompares++;
        conclude;
    end
endmodule
